//--- core/bidio_port.sv
/*
  eight-line bidirectional io port: data latch, direction register,
  read mux, bit operations, halt wake-up and pull-high controls.
  assumes a cpu data-memory strobe interface on clk_sys (25 mhz) and a
  pad ring that resolves pad_out/pad_oe into the wire.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bidio_defines.svh"
module bidio_port
  import bidio_pkg::*;
#(
  parameter bidio_byte_t WAKE_MASK = 8'hff,
  parameter logic        PULL_HIGH = 1'b1
)(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        halt_wdt_n,
  input  wire logic        halted,
  input  wire logic [7:0]  mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        phase2,
  input  wire logic        mem_wr,
  input  wire bidio_byte_t mem_wdata,
  input  wire logic        rmw_en,
  input  wire logic [1:0]  rmw_op,
  input  wire logic [2:0]  rmw_bit,
  input  wire logic        rmw_to_acc,
  input  wire bidio_byte_t pad_in,
  output var  bidio_byte_t mem_rdata,
  output var  logic        acc_wr,
  output var  bidio_byte_t pad_out,
  output var  bidio_byte_t pad_oe,
  output var  bidio_byte_t pad_pull_en,
  output var  bidio_byte_t pad_schmitt_en,
  output var  logic        wake_req
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  bidio_byte_t data_ff, nxt_data;
  bidio_byte_t dir_ff, nxt_dir;
  bidio_byte_t rdata_ff, nxt_rdata;
  bidio_byte_t oe_ff, nxt_oe;
  bidio_byte_t out_ff, nxt_out;
  bidio_byte_t pull_ff, nxt_pull;
  bidio_byte_t sch_ff, nxt_sch;
  bidio_byte_t prev_ff, nxt_prev;
  logic        wake_ff, nxt_wake;
  logic        accw_ff, nxt_accw;
  bidio_byte_t pad_sync;
  bidio_byte_t port_view;
  bidio_byte_t rmw_val;
  bidio_sel_e  sel;

  // address decode used by read, write and bit operations
  function automatic bidio_sel_e decode(input logic [7:0] a);
    if (a == `BIDIO_ADDR_DATA)
      decode = BIDIO_SEL_DATA;
    else if (a == `BIDIO_ADDR_DIR)
      decode = BIDIO_SEL_DIR;
    else
      decode = BIDIO_SEL_NONE;
  endfunction

  // ------------------------------------------------------------------
  // pad synchroniser
  // ------------------------------------------------------------------
  bidio_sync u_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .pad_in   (pad_in),
    .pad_sync (pad_sync)
  );

  // per-line mux: pad for inputs, latch for outputs
  always_comb begin
    sel       = decode(mem_addr);
    port_view = (dir_ff & pad_sync) | (~dir_ff & data_ff);
    rmw_val   = port_view;
    unique case (rmw_op)
      2'h0: rmw_val[rmw_bit] = 1'b1;
      2'h1: rmw_val[rmw_bit] = 1'b0;
      2'h2: rmw_val = ~port_view;
      2'h3: rmw_val = port_view;
    endcase
  end

  // register writes, read data and bit operations
  always_comb begin
    nxt_data  = data_ff;
    nxt_dir   = dir_ff;
    nxt_rdata = rdata_ff;
    nxt_accw  = 1'b0;
    if (mem_wr && sel == BIDIO_SEL_DATA)
      nxt_data = mem_wdata;
    if (mem_wr && sel == BIDIO_SEL_DIR)
      nxt_dir = mem_wdata;
    if (mem_rd && phase2) begin
      unique case (sel)
        BIDIO_SEL_DATA: nxt_rdata = port_view;
        BIDIO_SEL_DIR:  nxt_rdata = dir_ff;
        BIDIO_SEL_NONE: nxt_rdata = 8'h00;
      endcase
    end
    if (rmw_en && sel == BIDIO_SEL_DATA) begin
      if (rmw_to_acc) begin
        nxt_rdata = rmw_val;
        nxt_accw  = 1'b1;
      end else begin
        nxt_data = rmw_val;
      end
    end
  end

  // pad drive and wake detection
  always_comb begin
    nxt_oe   = ~nxt_dir;
    nxt_out  = nxt_data;
    nxt_pull = PULL_HIGH ? nxt_dir : 8'h00;
    nxt_sch  = nxt_dir;
    nxt_prev = pad_sync;
    nxt_wake = halted && |(prev_ff & ~pad_sync & WAKE_MASK & dir_ff);
  end

  // a halt-time watchdog reset holds the port state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      data_ff <= `BIDIO_RST_DATA;
      dir_ff  <= `BIDIO_RST_DIR;
      oe_ff   <= 8'h00;
      out_ff  <= `BIDIO_RST_DATA;
      pull_ff <= PULL_HIGH ? 8'hff : 8'h00;
      sch_ff  <= 8'hff;
    end else if (halt_wdt_n) begin
      data_ff <= nxt_data;
      dir_ff  <= nxt_dir;
      oe_ff   <= nxt_oe;
      out_ff  <= nxt_out;
      pull_ff <= nxt_pull;
      sch_ff  <= nxt_sch;
    end
  end

  // read path and wake flags carry no retained state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
      accw_ff  <= 1'b0;
      prev_ff  <= 8'hff;
      wake_ff  <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      accw_ff  <= nxt_accw;
      prev_ff  <= nxt_prev;
      wake_ff  <= nxt_wake;
    end
  end

  assign mem_rdata      = rdata_ff;
  assign acc_wr         = accw_ff;
  assign pad_out        = out_ff;
  assign pad_oe         = oe_ff;
  assign pad_pull_en    = pull_ff;
  assign pad_schmitt_en = sch_ff;
  assign wake_req       = wake_ff;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence port_write_s;
    mem_wr && decode(mem_addr) == BIDIO_SEL_DATA && halt_wdt_n && !rmw_en;
  endsequence

  latch_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    port_write_s |=> pad_out == $past(mem_wdata))
    else $error("latch write not seen on pads");
  latch_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(mem_wr || rmw_en) |=> $stable(data_ff))
    else $error("latch changed without write");
  dir_drive_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pad_oe == ~dir_ff)
    else $error("output enable disagrees with direction");
  read_mux_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    mem_rd && phase2 && sel == BIDIO_SEL_DATA && !rmw_en |=>
    mem_rdata == (($past(dir_ff) & $past(pad_sync)) |
                  (~$past(dir_ff) & $past(data_ff))))
    else $error("port read value wrong");
  schmitt_in_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pad_schmitt_en == ~pad_oe)
    else $error("schmitt enable not on inputs");
  pull_common_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pad_pull_en == (PULL_HIGH ? ~pad_oe : 8'h00))
    else $error("pull-high not common");
  rmw_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rmw_en && sel == BIDIO_SEL_DATA && !rmw_to_acc && rmw_op == 2'h0 &&
    halt_wdt_n && !mem_wr |=> data_ff[$past(rmw_bit)])
    else $error("bit set lost");
  wdt_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !halt_wdt_n |=> $stable(data_ff) && $stable(dir_ff))
    else $error("halt watchdog changed port");
  wake_edge_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wake_req |-> $past(halted) && |($past(prev_ff) & ~$past(pad_sync)
    & WAKE_MASK))
    else $error("wake without falling edge");
endmodule
`default_nettype wire

//--- core/bidio_defines.svh
/*
  constants for the bidirectional io port: addresses, reset values.
  assumes inclusion by bare name from core files.
*/
`ifndef BIDIO_DEFINES_SVH
`define BIDIO_DEFINES_SVH
// ------------------------------------------------------------------
// register addresses in data memory
// ------------------------------------------------------------------
`define BIDIO_ADDR_DATA 8'h12
`define BIDIO_ADDR_DIR  8'h13
// ------------------------------------------------------------------
// reset values and port width
// ------------------------------------------------------------------
`define BIDIO_RST_DATA  8'hff
`define BIDIO_RST_DIR   8'hff
`define BIDIO_WIDTH     8
`endif

//--- core/bidio_pkg.sv
/*
  types for the bidirectional io port.
  assumes nothing of its surroundings.
*/
package bidio_pkg;
  typedef logic [7:0] bidio_byte_t;
  // register access in progress
  typedef enum logic [1:0] {
    BIDIO_SEL_NONE,
    BIDIO_SEL_DATA,
    BIDIO_SEL_DIR
  } bidio_sel_e;
endpackage

//--- core/bidio_sync.sv
/*
  two-stage synchroniser for the eight pad inputs.
  assumes pads are any asynchronous level; clk_sys drives it.
*/
`timescale 1ns/1ns
`default_nettype none
module bidio_sync
  import bidio_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire bidio_byte_t pad_in,
  output var  bidio_byte_t pad_sync
);
  bidio_byte_t stage1_ff;
  bidio_byte_t stage2_ff;
  bidio_byte_t nxt_stage1;
  bidio_byte_t nxt_stage2;

  // stage one is read only by stage two
  always_comb begin
    nxt_stage1 = pad_in;
    nxt_stage2 = stage1_ff;
  end

  // pads idle high with pull-high, so reset to ones avoids false edges
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1_ff <= 8'hff;
      stage2_ff <= 8'hff;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign pad_sync = stage2_ff;
endmodule
`default_nettype wire

//--- verif/bidio_pads.sv
/*
  pad-side model: resolves each io wire from the port and the far side.
  assumes the port drives pad_out where pad_oe is high.
*/
`timescale 1ns/1ns
`default_nettype none
module bidio_pads
  import bidio_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire bidio_byte_t pad_out,
  input  wire bidio_byte_t pad_oe,
  input  wire bidio_byte_t pad_pull_en,
  input  wire bidio_byte_t ext_val,
  input  wire bidio_byte_t ext_drv,
  output var  bidio_byte_t pad_in
);
  bidio_byte_t float_ff = 8'h00;
  // an undriven line wanders, so a stale level never passes for a read
  always @(posedge clk_sys) float_ff <= ~float_ff;
  // wire level: port first, then far side, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_drv[i]) pad_in[i] = ext_val[i];
      else if (pad_pull_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = float_ff[i];
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
/*
  self-checking bench for the io port: registers, bit ops, resets, wake.
  assumes the pad model and the design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bidio_defines.svh"
module tb_top
  import bidio_pkg::*;
;
  logic        clk_sys = 0, arst_n = 0, halt_wdt_n = 1, halted = 0;
  logic        mem_rd = 0, phase2 = 0, mem_wr = 0, rmw_en = 0;
  logic        rmw_to_acc = 0;
  logic [7:0]  mem_addr = 8'h00;
  logic [1:0]  rmw_op = 2'h3;
  logic [2:0]  rmw_bit = 3'h0;
  bidio_byte_t mem_wdata = 8'h00, ext_val = 8'h00, ext_drv = 8'h00, rd;
  wire logic   acc_wr, wake_req;
  wire bidio_byte_t pad_in, mem_rdata, pad_out, pad_oe;
  wire bidio_byte_t pad_pull_en, pad_schmitt_en;
  int          errors = 0, num_checks = 0;
  bidio_port uut (.clk_sys(clk_sys), .arst_n(arst_n), .halt_wdt_n(halt_wdt_n),
    .halted(halted), .mem_addr(mem_addr), .mem_rd(mem_rd), .phase2(phase2),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .rmw_en(rmw_en), .rmw_op(rmw_op),
    .rmw_bit(rmw_bit), .rmw_to_acc(rmw_to_acc), .pad_in(pad_in),
    .mem_rdata(mem_rdata), .acc_wr(acc_wr), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_en(pad_pull_en), .pad_schmitt_en(pad_schmitt_en),
    .wake_req(wake_req));
  bidio_pads pads (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_en(pad_pull_en), .ext_val(ext_val), .ext_drv(ext_drv),
    .pad_in(pad_in));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // every input change lands 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input bidio_byte_t seen, input bidio_byte_t exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // each request lets one idle edge pass first, so a strobe that the
  // previous call dropped is seen low before it rises again
  task automatic wr(input logic [7:0] a, input bidio_byte_t d);
    cyc(1);
    mem_addr  = a;
    mem_wdata = d;
    mem_wr    = 1;
    cyc(1);
    mem_wr    = 0;
  endtask
  // read strobe and sample phase stand together for one edge
  task automatic rdr(input logic [7:0] a);
    cyc(1);
    mem_addr = a;
    mem_rd   = 1;
    phase2   = 1;
    cyc(1);
    mem_rd   = 0;
    phase2   = 0;
    rd       = mem_rdata;
  endtask
  task automatic rmw(input logic [1:0] op, input logic [2:0] b,
                     input logic       acc);
    cyc(1);
    mem_addr   = `BIDIO_ADDR_DATA;
    rmw_op     = op;
    rmw_bit    = b;
    rmw_to_acc = acc;
    rmw_en     = 1;
    cyc(1);
    rmw_en     = 0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdr(`BIDIO_ADDR_DATA);
    chk(rd, 8'hff);
    rdr(`BIDIO_ADDR_DIR);
    chk(rd, 8'hff);
    chk(pad_oe, 8'h00);
    chk(pad_pull_en, 8'hff);
    chk(pad_schmitt_en, 8'hff);
    $display("test reset done");
  endtask
  // mixed directions: low nibble input from far side, high nibble latch
  task automatic t_rw();
    wr(`BIDIO_ADDR_DIR, 8'h0f);
    wr(`BIDIO_ADDR_DATA, 8'h5a);
    chk(pad_out, 8'h5a);
    chk(pad_oe, 8'hf0);
    chk(pad_schmitt_en, 8'h0f);
    ext_drv = 8'h0f;
    ext_val = 8'h33;
    cyc(3);
    rdr(`BIDIO_ADDR_DATA);
    chk(rd, 8'h53);
    ext_val = 8'h3c;
    cyc(3);
    rdr(`BIDIO_ADDR_DATA);
    chk(rd, 8'h5c);
    rdr(`BIDIO_ADDR_DIR);
    chk(rd, 8'h0f);
    rdr(8'h20);
    chk(rd, 8'h00);
    wr(8'h20, 8'h00);
    chk(pad_out, 8'h5a);
    ext_drv = 8'h00;
    $display("test rw done");
  endtask
  task automatic t_rmw();
    wr(`BIDIO_ADDR_DIR, 8'h00);
    wr(`BIDIO_ADDR_DATA, 8'h0f);
    rmw(2'h0, 3'h7, 0);
    chk(pad_out, 8'h8f);
    rmw(2'h1, 3'h1, 0);
    chk(pad_out, 8'h8d);
    rmw(2'h2, 3'h0, 0);
    chk(pad_out, 8'h72);
    rmw(2'h0, 3'h0, 1);
    chk(mem_rdata, 8'h73);
    chk({7'h00, acc_wr}, 8'h01);
    chk(pad_out, 8'h72);
    cyc(1);
    chk({7'h00, acc_wr}, 8'h00);
    $display("test rmw done");
  endtask
  // watchdog in halt keeps state; external reset in halt restores it
  task automatic t_wdt();
    halted     = 1;
    halt_wdt_n = 0;
    wr(`BIDIO_ADDR_DATA, 8'h11);
    wr(`BIDIO_ADDR_DIR, 8'hff);
    chk(pad_out, 8'h72);
    chk(pad_oe, 8'hff);
    rdr(`BIDIO_ADDR_DIR);
    chk(rd, 8'h00);
    halt_wdt_n = 1;
    arst_n     = 0;
    cyc(2);
    arst_n     = 1;
    cyc(1);
    chk(pad_out, 8'hff);
    chk(pad_oe, 8'h00);
    rdr(`BIDIO_ADDR_DATA);
    chk(rd, 8'hff);
    rdr(`BIDIO_ADDR_DIR);
    chk(rd, 8'hff);
    halted     = 0;
    $display("test wdt done");
  endtask
  task automatic t_wake();
    int          n;
    bidio_byte_t seen;
    halted  = 1;
    ext_drv = 8'h01;
    ext_val = 8'h01;
    cyc(4);
    ext_val = 8'h00;
    n       = 0;
    while (wake_req !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    chk({7'h00, wake_req}, 8'h01);
    cyc(1);
    chk({7'h00, wake_req}, 8'h00);
    // a rising edge must not wake, only a falling one
    seen    = 8'h00;
    ext_val = 8'h01;
    repeat (6) begin
      cyc(1);
      seen = seen | {7'h00, wake_req};
    end
    chk(seen, 8'h00);
    // outside halt a falling edge raises no wake request
    halted  = 0;
    ext_val = 8'h00;
    repeat (6) begin
      cyc(1);
      seen = seen | {7'h00, wake_req};
    end
    chk(seen, 8'h00);
    ext_drv = 8'h00;
    $display("test wake done");
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog: the whole run needs well under 200 cycles
  initial begin
    #20000;
    errors++;
    finish_test();
  end
  initial begin
    cyc(2); arst_n = 1; cyc(1);
    t_reset(); t_rw(); t_rmw(); t_wdt(); t_wake();
    finish_test();
  end
endmodule
`default_nettype wire
